// *** inc/fld_pkg.sv ***
// Package for the flash LED driver control logic.
// Holds register offsets, field positions, reset values, timing counts
// and the serial slave state encoding; shared by all design files.

package fld_pkg;

  // ==========================================================
  // Register map
  localparam logic [7:0] CMD_OFFSET = 8'h00;
  localparam logic [7:0] DIM_OFFSET = 8'h01;
  localparam logic [7:0] IND_OFFSET = 8'h02;
  localparam logic [7:0] STAT_OFFSET = 8'h03;

  localparam logic [7:0] CMD_RESET = 8'h00;
  localparam logic [7:0] DIM_RESET = 8'h00;
  localparam logic [7:0] IND_RESET = 8'h00;
  localparam logic [7:0] STAT_RESET = 8'h00;

  // ==========================================================
  // Field positions
  localparam int PWR_BIT = 7;
  localparam int FLASH_TRIGGER_PIN_BIT = 6;
  localparam int TORCH_BIT = 5;
  localparam int NTC_BIT = 4;
  localparam int HI_LSB = 4;
  localparam int LO_LSB = 0;
  localparam int CODE_W = 4;

  localparam int RUN_BIT = 6;
  localparam int OPEN_BIT = 5;
  localparam int WARN_BIT = 4;
  localparam int HOT_BIT = 3;
  localparam int DIE_BIT = 2;
  localparam int SHORT_BIT = 0;

  // ==========================================================
  // Current steps and timer codes
  localparam logic [4:0] TORCH_STEP_BASE = 5'h01;
  localparam logic [4:0] FLASH_STEP_BASE = 5'h09;
  localparam logic [3:0] ONTIME_CONT = 4'hF;
  localparam logic [3:0] ONTIME_NONE = 4'h0;

  // ==========================================================
  // Timing
  localparam int CLK_HZ = 100_000_000;
  localparam int STEP_MS = 100;
  localparam int STEP_CYCLES = CLK_HZ / 1000 * STEP_MS;
  localparam int PRE_W = 24;

  // Serial slave address, address strap tied low
  localparam logic [6:0] DEV_ADDR = 7'h30;

  // ==========================================================
  // Serial slave states
  typedef enum logic [7:0] {
    ST_IDLE = 8'h01,
    ST_ADDR = 8'h02,
    ST_SUB = 8'h04,
    ST_WR = 8'h08,
    ST_ACK_A = 8'h10,
    ST_ACK_RX = 8'h20,
    ST_RD = 8'h40,
    ST_MACK = 8'h80
  } fld_i2c_state_e;

endpackage

// *** tb/fld_host_model.sv ***
// Host model: serial bus master with register access tasks.
// Assumes the bench resolves the data wire and feeds it back on sda.
`timescale 1ns/100ps
`default_nettype none
module fld_host_model
(
  input wire logic sys_clk,
  input wire logic sda,
  output logic scl,
  output logic sda_drv
);
  // Idle bus: both lines released high
  initial
  begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end
  // One clock phase; data moves one cycle after the clock edge
  task automatic ph(input logic c, input logic d);
    @(posedge sys_clk);
    scl <= c;
    @(posedge sys_clk);
    sda_drv <= d;
    repeat (2) @(posedge sys_clk);
  endtask
  // One bit, sampled in the high phase
  task automatic bt(input logic d, output logic r);
    ph(1'b0, d);
    ph(1'b1, d);
    r = sda;
  endtask
  // Byte, MSB first, then the ninth bit driven as m
  task automatic xb(input logic [7:0] d, input logic m,
    output logic [7:0] q, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      bt(d[i], q[i]);
    bt(m, r);
    ack = !r;
  endtask
  task automatic start();
    ph(1'b0, 1'b1);
    ph(1'b1, 1'b1);
    ph(1'b1, 1'b0);
  endtask
  task automatic stop();
    ph(1'b0, 1'b0);
    ph(1'b1, 1'b0);
    ph(1'b1, 1'b1);
  endtask
  // Write burst from sub-address s; ok when every byte was acked
  task automatic wr(input logic [6:0] a, input logic [7:0] s,
    input logic [7:0] d[$], output logic ok);
    logic [7:0] q;
    logic k;
    start();
    xb({a, 1'b0}, 1'b1, q, ok);
    xb(s, 1'b1, q, k);
    ok &= k;
    foreach (d[i])
    begin
      xb(d[i], 1'b1, q, k);
      ok &= k;
    end
    stop();
  endtask
  // Read n bytes from s; master acks all but the last
  task automatic rd(input logic [7:0] s, input int n,
    output logic [7:0] q[$]);
    logic [7:0] b;
    logic k;
    q = {};
    start();
    xb({fld_pkg::DEV_ADDR, 1'b0}, 1'b1, b, k);
    xb(s, 1'b1, b, k);
    start();
    xb({fld_pkg::DEV_ADDR, 1'b1}, 1'b1, b, k);
    for (int i = 0; i < n; i++)
    begin
      xb(8'hFF, i == n - 1, b, k);
      q.push_back(b);
    end
    stop();
  endtask
endmodule
`default_nettype wire

// *** tb/fld_regs_sva.sv ***
// Checker for the flash LED control block, bound to its top ports.
// Assumes one clock domain with synchronous active-low reset.
`timescale 1ns/100ps
`default_nettype none
module fld_regs_sva
#(
  parameter int STEP_CYCLES = 10
)
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic scl_in,
  input wire logic sda_oe_n,
  input wire logic flash_trigger_pin,
  input wire logic analog_enable,
  input wire logic flash_mode,
  input wire logic torch_mode,
  input wire logic [4:0] led_step,
  input wire logic temp_monitor_on,
  input wire logic indicator_on,
  input wire logic [3:0] indicator_level
);
  localparam int LIM = 15 * STEP_CYCLES + 2;
  int flash_cnt;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // Length of the current flash
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n || !flash_mode)
      flash_cnt <= 0;
    else
      flash_cnt <= flash_cnt + 1;
  end
  // ==========================================================
  // Properties
  sequence s_standby;
    !analog_enable [*2];
  endsequence
  sequence s_led_busy;
    (flash_mode || torch_mode) [*2];
  endsequence
  a_flash_needs_power: assert property (flash_mode |-> analog_enable)
    else $error("flash without power");
  a_flash_step_range: assert property (flash_mode [*2] |->
    led_step >= 5'h09 && led_step <= 5'h18) else $error("flash step");
  a_torch_step_range: assert property ((torch_mode && !flash_mode) [*2]
    |-> led_step >= 5'h01 && led_step <= 5'h10) else $error("torch step");
  a_monitor_when_busy: assert property (s_led_busy |-> temp_monitor_on)
    else $error("monitor off in torch or flash");
  a_indicator_ready: assert property (s_led_busy or s_standby
    |-> !indicator_on) else $error("indicator outside ready");
  a_standby_quiet: assert property (s_standby
    |-> !flash_mode && !torch_mode) else $error("active in standby");
  a_level_gated: assert property (!indicator_on
    |-> indicator_level == 4'h0) else $error("level while off");
  a_flash_pin_gate: assert property (!flash_trigger_pin [*4]
    |-> !flash_mode) else $error("flash without pin");
  a_flash_time_limit: assert property (flash_cnt <= LIM)
    else $error("flash past longest time-out");
  a_ack_in_low: assert property ($changed(sda_oe_n) |-> !scl_in)
    else $error("data line moved with clock high");
endmodule
bind fld_regs fld_regs_sva #(.STEP_CYCLES(STEP_CYCLES)) chk_i (.sys_clk,
  .rst_n, .scl_in, .sda_oe_n, .flash_trigger_pin, .analog_enable,
  .flash_mode, .torch_mode, .led_step, .temp_monitor_on, .indicator_on,
  .indicator_level);
`default_nettype wire

// *** tb/fld_regs_tb.sv ***
// Testbench for the flash LED control block with a serial host model.
// Assumes the checker is bound separately; short step count in use.
`timescale 1ns/100ps
`default_nettype none
module fld_regs_tb;
  localparam int ST = 100;
  localparam logic [7:0] EXP [5] = '{8'h20, 8'h10, 8'h08, 8'h04, 8'h01};
  // Rows: sub-address, written byte, byte read back
  localparam logic [23:0] ROWS [5] = '{24'h009A9A, 24'h01A5A5,
    24'h023F3F, 24'h03FF00, 24'h045500};
  logic sys_clk, rst_n, scl_in, sda_in, host_sda, sda_out, sda_oe_n;
  logic flash_trigger_pin, attention_out, attention_oe_n, analog_enable;
  logic flash_mode, torch_mode, temp_monitor_on, indicator_on, ok;
  logic [4:0] led_step, ev;
  logic [3:0] indicator_level;
  logic [7:0] b;
  logic [7:0] q[$];
  int fails, n_tests, n;
  // Wire-and of both data drivers with pull-up
  assign sda_in = host_sda & (sda_oe_n | sda_out);
  fld_regs #(.STEP_CYCLES(ST)) uut (.sys_clk, .rst_n, .scl_in, .sda_in,
    .sda_out, .sda_oe_n, .flash_trigger_pin, .attention_out,
    .attention_oe_n, .open_led_event(ev[4]), .temp_warn_event(ev[3]),
    .overtemp_event(ev[2]), .die_overtemp_event(ev[1]),
    .output_short_event(ev[0]), .analog_enable, .flash_mode, .torch_mode,
    .led_step, .temp_monitor_on, .indicator_on, .indicator_level);
  fld_host_model host (.sys_clk, .sda(sda_in), .scl(scl_in),
    .sda_drv(host_sda));
  // Clock and watchdog
  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  initial
  begin
    repeat (90000) @(posedge sys_clk);
    fails++;
    give_verdict();
  end
  // ==========================================================
  // Helpers
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      fails++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic give_verdict();
    if (fails == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic rdr(input logic [7:0] s, output logic [7:0] r);
    logic [7:0] t[$];
    host.rd(s, 1, t);
    r = t[0];
  endtask
  task automatic wr1(input logic [7:0] s, input logic [7:0] d);
    q = {d};
    host.wr(fld_pkg::DEV_ADDR, s, q, ok);
  endtask
  task automatic wait_fm();
    for (int i = 0; i < 1000 && flash_mode !== 1'b1; i++)
      @(negedge sys_clk);
    if (flash_mode !== 1'b1)
    begin
      fails++;
      give_verdict();
    end
  endtask
  // ==========================================================
  // Main sequence
  initial
  begin
    rst_n = 1'b0;
    flash_trigger_pin = 1'b0;
    ev = 5'h00;
    repeat (3) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (2) @(negedge sys_clk);
    chk({3'h0, sda_out, attention_out, attention_oe_n, sda_oe_n,
      analog_enable}, 8'h06);
    for (int i = 0; i < 4; i++)
    begin
      rdr(8'(i), b);
      chk(b, 8'h00);
    end
    foreach (ROWS[i])
    begin
      wr1(ROWS[i][23:16], ROWS[i][15:8]);
      chk({7'h0, ok}, 8'h01);
      rdr(ROWS[i][23:16], b);
      chk(b, ROWS[i][7:0]);
    end
    chk({4'h0, analog_enable, temp_monitor_on, indicator_on, torch_mode},
      8'h0E);
    chk({4'h0, indicator_level}, 8'h03);
    q = {8'h77};
    host.wr(7'h31, 8'h01, q, ok);
    chk({7'h0, ok}, 8'h00);
    q = {8'h12, 8'h34};
    host.wr(fld_pkg::DEV_ADDR, 8'h01, q, ok);
    host.rd(8'h01, 2, q);
    chk(q[0], 8'h12);
    chk(q[1], 8'h34);
    // Torch at code 1, monitor bit clear
    wr1(8'h00, 8'hA0);
    chk({5'h0, torch_mode, temp_monitor_on, indicator_on}, 8'h06);
    chk({3'h0, led_step}, 8'h02);
    // Pin-timed flash with time-out code 3
    wr1(8'h00, 8'hC3);
    chk({7'h0, flash_mode}, 8'h00);
    @(posedge sys_clk);
    flash_trigger_pin <= 1'b1;
    wait_fm();
    chk({3'h0, led_step}, 8'h0B);
    n = 0;
    while (flash_mode === 1'b1 && n < 2000)
    begin
      @(negedge sys_clk);
      n++;
    end
    chk({7'h0, n >= 3 * ST - 1 && n <= 3 * ST + 1}, 8'h01);
    repeat (2) @(negedge sys_clk);
    chk({6'h0, attention_out, attention_oe_n}, 8'h00);
    rdr(8'h00, b);
    chk(b, 8'h83);
    rdr(8'h03, b);
    chk(b, 8'h00);
    chk({7'h0, attention_oe_n}, 8'h01);
    // Soft flash with the pin held high
    wr1(8'h00, 8'hCF);
    wait_fm();
    rdr(8'h03, b);
    chk(b, 8'h40);
    wr1(8'h00, 8'h8F);
    chk({6'h0, flash_mode, attention_oe_n}, 8'h01);
    // Each fault event latches its bit until read
    for (int i = 0; i < 5; i++)
    begin
      @(posedge sys_clk);
      ev <= 5'h10 >> i;
      @(posedge sys_clk);
      ev <= 5'h00;
      repeat (3) @(negedge sys_clk);
      chk({7'h0, attention_oe_n}, 8'h00);
      rdr(8'h03, b);
      chk(b, EXP[i]);
      rdr(8'h03, b);
      chk(b, 8'h00);
    end
    // Indicator on-time 2 steps, then continuous, then off
    wr1(8'h02, 8'h52);
    chk({3'h0, indicator_on, indicator_level}, 8'h15);
    repeat (2 * ST + 10) @(negedge sys_clk);
    chk({7'h0, indicator_on}, 8'h00);
    wr1(8'h02, 8'h5F);
    repeat (3 * ST) @(negedge sys_clk);
    chk({7'h0, indicator_on}, 8'h01);
    wr1(8'h02, 8'h0F);
    chk({7'h0, indicator_on}, 8'h00);
    // Shutdown clears dimming and indicator registers
    wr1(8'h00, 8'h00);
    chk({7'h0, analog_enable}, 8'h00);
    rdr(8'h01, b);
    chk(b, 8'h00);
    rdr(8'h02, b);
    chk(b, 8'h00);
    give_verdict();
  end
endmodule
`default_nettype wire

// *** verilog/fld_regs.sv ***
// Flash LED driver control: serial slave, register bank, flash gating,
// flash time-out and indicator on-time. Pins sampled on sys_clk.
// Analog fault inputs are level events from the power stage.
//
// Function
// - Four 8-bit registers at 00..03; status at 03 is read only.
// - Command bits: power, soft trigger, torch, temp monitor, timeout code.
// - Power bit enables analog blocks; zero leaves only the serial logic.
// - Flash active is soft trigger enable AND trigger pin level.
// - Flash only with power bit set; current follows flash level code.
// - Torch enable in ready mode enters torch at torch level code.
// - Temp comparators on in ready only if enabled; always in torch/flash.
// - Timeout code 0..15 gives 0..1.5 s in 100 ms steps.
// - Entering flash loads the time counter and counts down while on.
// - Counter at zero clears soft trigger and pulls attention low.
// - Expiry leaves the stored timeout code unchanged.
// - Dimming register: torch code high, flash code low; clears on shutdown.
// - Each 4-bit current code selects one of 16 levels.
// - Torch codes map to steps 1..16, flash codes to steps 9..24.
// - Indicator register: current code high, on-time low; shutdown clears.
// - Indicator current from code, lit only in ready mode.
// - Writing a nonzero indicator current code starts the on-time timer.
// - On-time codes 1..14 give 100..1400 ms; 15 means continuous.
// - Only current code writes switch the indicator on; timer end or shutdown also switch it off.
// - Status bits 6,5,4,3,2,0 as listed; bits 7 and 1 zero.
// - Register pointer increments after each completed data byte.
// - Latched status bits clear on status read; run flag is live.
// - Run flag high while flash runs, cleared at end or timeout.

`timescale 1ns/100ps
`default_nettype none

module fld_regs
#(
  parameter int STEP_CYCLES = fld_pkg::STEP_CYCLES
)
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  input wire logic flash_trigger_pin,
  output logic attention_out,
  output logic attention_oe_n,
  input wire logic open_led_event,
  input wire logic temp_warn_event,
  input wire logic overtemp_event,
  input wire logic die_overtemp_event,
  input wire logic output_short_event,
  output logic analog_enable,
  output logic flash_mode,
  output logic torch_mode,
  output logic [4:0] led_step,
  output logic temp_monitor_on,
  output logic indicator_on,
  output logic [3:0] indicator_level
);

  fld_pkg::fld_i2c_state_e state_reg;
  logic scl_q, sda_q;
  logic scl_rise, scl_fall, start_seen, stop_seen;
  logic [3:0] cnt_reg;
  logic [7:0] shift_reg;
  logic [7:0] ptr_reg;
  logic rw_reg, mack_reg;
  logic wr_strobe, rd_done, stat_read;
  logic [7:0] rdata;
  logic [7:0] cmd_reg, current_dimming, ind_reg;
  logic [7:0] latch_reg;
  logic timeout_reg;
  logic shutdown_now;
  logic power_up_bit, soft_trigger_enable, torch_enable;
  logic led_temp_monitor_enable, flash_active, fault_block;
  logic flash_req, flash_entry, flash_expire, flash_zero;
  logic [3:0] flash_timeout_code, torch_level_code, flash_level_code;
  logic [3:0] indicator_current_code, indicator_ontime_code;
  logic ind_lit_reg, ind_timing_reg, ind_load, ind_zero, ind_expire;
  logic ready_mode;

  // ==========================================================
  // Bus line edges
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end
    else
    begin
      scl_q <= scl_in;
      sda_q <= sda_in;
    end
  end

  assign scl_rise = !scl_q && scl_in;
  assign scl_fall = scl_q && !scl_in;
  assign start_seen = scl_q && scl_in && sda_q && !sda_in;
  assign stop_seen = scl_q && scl_in && !sda_q && sda_in;

  // ==========================================================
  // Serial slave framing, ack drive and pointer
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      state_reg <= fld_pkg::ST_IDLE;
      cnt_reg <= 4'h0;
      shift_reg <= 8'h00;
      ptr_reg <= 8'h00;
      rw_reg <= 1'b0;
      mack_reg <= 1'b0;
      sda_oe_n <= 1'b1;
    end
    else if (start_seen)
    begin
      state_reg <= fld_pkg::ST_ADDR;
      cnt_reg <= 4'h0;
      sda_oe_n <= 1'b1;
    end
    else if (stop_seen)
    begin
      state_reg <= fld_pkg::ST_IDLE;
      sda_oe_n <= 1'b1;
    end
    else
    begin
      unique case (state_reg)
        fld_pkg::ST_IDLE:
          cnt_reg <= 4'h0;
        fld_pkg::ST_ADDR, fld_pkg::ST_SUB, fld_pkg::ST_WR:
          if (scl_rise && cnt_reg != 4'h8)
          begin
            shift_reg <= {shift_reg[6:0], sda_in};
            cnt_reg <= cnt_reg + 4'h1;
          end
          else if (scl_fall && cnt_reg == 4'h8)
          begin
            cnt_reg <= 4'h0;
            sda_oe_n <= 1'b0;
            if (state_reg == fld_pkg::ST_ADDR)
            begin
              rw_reg <= shift_reg[0];
              state_reg <= fld_pkg::ST_ACK_A;
              if (shift_reg[7:1] != fld_pkg::DEV_ADDR)
              begin
                state_reg <= fld_pkg::ST_IDLE;
                sda_oe_n <= 1'b1;
              end
            end
            else if (state_reg == fld_pkg::ST_SUB)
            begin
              ptr_reg <= shift_reg;
              state_reg <= fld_pkg::ST_ACK_RX;
            end
            else
            begin
              ptr_reg <= ptr_reg + 8'h01;
              state_reg <= fld_pkg::ST_ACK_RX;
            end
          end
        fld_pkg::ST_ACK_A:
          if (scl_fall)
          begin
            if (rw_reg)
            begin
              state_reg <= fld_pkg::ST_RD;
              shift_reg <= rdata;
              sda_oe_n <= rdata[7];
            end
            else
            begin
              state_reg <= fld_pkg::ST_SUB;
              sda_oe_n <= 1'b1;
            end
          end
        fld_pkg::ST_ACK_RX:
          if (scl_fall)
          begin
            state_reg <= fld_pkg::ST_WR;
            sda_oe_n <= 1'b1;
          end
        fld_pkg::ST_RD:
          if (scl_rise)
            cnt_reg <= cnt_reg + 4'h1;
          else if (scl_fall)
          begin
            if (cnt_reg == 4'h8)
            begin
              cnt_reg <= 4'h0;
              sda_oe_n <= 1'b1;
              ptr_reg <= ptr_reg + 8'h01;
              state_reg <= fld_pkg::ST_MACK;
            end
            else
            begin
              shift_reg <= {shift_reg[6:0], 1'b0};
              sda_oe_n <= shift_reg[6];
            end
          end
        fld_pkg::ST_MACK:
          if (scl_rise)
            mack_reg <= !sda_in;
          else if (scl_fall)
          begin
            if (mack_reg)
            begin
              state_reg <= fld_pkg::ST_RD;
              shift_reg <= rdata;
              sda_oe_n <= rdata[7];
            end
            else
              state_reg <= fld_pkg::ST_IDLE;
          end
      endcase
    end
  end

  // Open-drain data line only ever pulls low
  always_ff @(posedge sys_clk)
  begin
    sda_out <= 1'b0;
  end

  // Byte strobes
  assign wr_strobe = (state_reg == fld_pkg::ST_WR) && !start_seen &&
                     !stop_seen && scl_fall && cnt_reg == 4'h8;
  assign rd_done = (state_reg == fld_pkg::ST_RD) && !start_seen &&
                   !stop_seen && scl_fall && cnt_reg == 4'h8;
  assign stat_read = rd_done && ptr_reg == fld_pkg::STAT_OFFSET;

  // ==========================================================
  // Register fields
  assign power_up_bit = cmd_reg[fld_pkg::PWR_BIT];
  assign soft_trigger_enable = cmd_reg[fld_pkg::FLASH_TRIGGER_PIN_BIT];
  assign torch_enable = cmd_reg[fld_pkg::TORCH_BIT];
  assign led_temp_monitor_enable = cmd_reg[fld_pkg::NTC_BIT];
  assign flash_timeout_code = cmd_reg[fld_pkg::LO_LSB +: fld_pkg::CODE_W];
  assign torch_level_code = current_dimming[fld_pkg::HI_LSB +: fld_pkg::CODE_W];
  assign flash_level_code = current_dimming[fld_pkg::LO_LSB +: fld_pkg::CODE_W];
  assign indicator_current_code = ind_reg[fld_pkg::HI_LSB +: fld_pkg::CODE_W];
  assign indicator_ontime_code = ind_reg[fld_pkg::LO_LSB +: fld_pkg::CODE_W];

  // Write clearing the power bit enters shutdown
  assign shutdown_now = wr_strobe && ptr_reg == fld_pkg::CMD_OFFSET &&
                        !shift_reg[fld_pkg::PWR_BIT];

  // Read data mux, unmapped pointers read zero
  always_comb
  begin
    rdata = 8'h00;
    unique case (ptr_reg)
      fld_pkg::CMD_OFFSET: rdata = cmd_reg;
      fld_pkg::DIM_OFFSET: rdata = current_dimming;
      fld_pkg::IND_OFFSET: rdata = ind_reg;
      fld_pkg::STAT_OFFSET: rdata = latch_reg |
        (8'(flash_mode) << fld_pkg::RUN_BIT);
      default: rdata = 8'h00;
    endcase
  end

  // ==========================================================
  // Command register; expiry clears only the trigger bit
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      cmd_reg <= fld_pkg::CMD_RESET;
    else
    begin
      if (wr_strobe && ptr_reg == fld_pkg::CMD_OFFSET)
        cmd_reg <= shift_reg;
      if (flash_expire)
        cmd_reg[fld_pkg::FLASH_TRIGGER_PIN_BIT] <= 1'b0;
    end
  end

  // Dimming and indicator registers, cleared on shutdown
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n || shutdown_now)
    begin
      current_dimming <= fld_pkg::DIM_RESET;
      ind_reg <= fld_pkg::IND_RESET;
    end
    else if (wr_strobe && ptr_reg == fld_pkg::DIM_OFFSET)
      current_dimming <= shift_reg;
    else if (wr_strobe && ptr_reg == fld_pkg::IND_OFFSET)
      ind_reg <= shift_reg;
  end

  // ==========================================================
  // Latched status and time-out flag; a new event beats a read clear
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      latch_reg <= fld_pkg::STAT_RESET;
      timeout_reg <= 1'b0;
    end
    else
    begin
      latch_reg <= (stat_read || shutdown_now) ? 8'h00 : latch_reg;
      latch_reg[fld_pkg::OPEN_BIT] <= open_led_event ||
        (latch_reg[fld_pkg::OPEN_BIT] && !stat_read && !shutdown_now);
      latch_reg[fld_pkg::WARN_BIT] <= temp_warn_event ||
        (latch_reg[fld_pkg::WARN_BIT] && !stat_read && !shutdown_now);
      latch_reg[fld_pkg::HOT_BIT] <= overtemp_event ||
        (latch_reg[fld_pkg::HOT_BIT] && !stat_read && !shutdown_now);
      latch_reg[fld_pkg::DIE_BIT] <= die_overtemp_event ||
        (latch_reg[fld_pkg::DIE_BIT] && !stat_read && !shutdown_now);
      latch_reg[fld_pkg::SHORT_BIT] <= output_short_event ||
        (latch_reg[fld_pkg::SHORT_BIT] && !stat_read && !shutdown_now);
      timeout_reg <= flash_expire || (timeout_reg && !stat_read);
    end
  end

  // Faults that force ready mode
  assign fault_block = latch_reg[fld_pkg::OPEN_BIT] ||
                       latch_reg[fld_pkg::HOT_BIT] ||
                       latch_reg[fld_pkg::DIE_BIT] ||
                       latch_reg[fld_pkg::SHORT_BIT];

  // ==========================================================
  // Flash gating and time-out
  assign flash_active = soft_trigger_enable && flash_trigger_pin;
  assign flash_req = flash_active && power_up_bit && !fault_block;
  assign flash_entry = flash_req && !flash_mode;
  assign flash_expire = flash_mode && flash_zero;

  fld_step_timer #(
    .STEP_CYCLES(STEP_CYCLES)
  ) u_flash_timer (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .load(flash_entry),
    .load_steps(flash_timeout_code),
    .run(flash_mode),
    .steps_zero(flash_zero)
  );

  // Mode and current outputs
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      analog_enable <= 1'b0;
      flash_mode <= 1'b0;
      torch_mode <= 1'b0;
      led_step <= 5'h00;
      temp_monitor_on <= 1'b0;
    end
    else
    begin
      analog_enable <= power_up_bit;
      flash_mode <= flash_req && !flash_expire;
      torch_mode <= power_up_bit && torch_enable && !flash_req &&
                    !fault_block;
      if (flash_req && !flash_expire)
        led_step <= fld_pkg::FLASH_STEP_BASE + 5'(flash_level_code);
      else if (power_up_bit && torch_enable && !fault_block)
        led_step <= fld_pkg::TORCH_STEP_BASE + 5'(torch_level_code);
      else
        led_step <= 5'h00;
      temp_monitor_on <= power_up_bit && (led_temp_monitor_enable ||
                         flash_mode || torch_mode);
    end
  end

  // Attention pulled low for time-out or any latched fault
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      attention_out <= 1'b0;
      attention_oe_n <= 1'b1;
    end
    else
    begin
      attention_out <= 1'b0;
      // Expiry pulls the pin in the same edge that clears the trigger bit
      attention_oe_n <= !(flash_expire || timeout_reg ||
                          |latch_reg);
    end
  end

  // ==========================================================
  // Indicator on-time
  assign ready_mode = power_up_bit && !flash_mode && !torch_mode;
  assign ind_load = wr_strobe && ptr_reg == fld_pkg::IND_OFFSET &&
                    shift_reg[fld_pkg::HI_LSB +: fld_pkg::CODE_W] != 4'h0;
  assign ind_expire = ind_timing_reg && ind_zero && !ind_load;

  fld_step_timer #(
    .STEP_CYCLES(STEP_CYCLES)
  ) u_ind_timer (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .load(ind_load),
    .load_steps(shift_reg[fld_pkg::LO_LSB +: fld_pkg::CODE_W]),
    .run(ind_timing_reg),
    .steps_zero(ind_zero)
  );

  // Lit state changes only on current code writes, timer end or shutdown
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n || shutdown_now)
    begin
      ind_lit_reg <= 1'b0;
      ind_timing_reg <= 1'b0;
    end
    else if (ind_load)
    begin
      ind_lit_reg <= 1'b1;
      ind_timing_reg <= shift_reg[fld_pkg::LO_LSB +: fld_pkg::CODE_W] !=
        fld_pkg::ONTIME_CONT && shift_reg[fld_pkg::LO_LSB +:
        fld_pkg::CODE_W] != fld_pkg::ONTIME_NONE;
    end
    else if (wr_strobe && ptr_reg == fld_pkg::IND_OFFSET)
    begin
      ind_lit_reg <= 1'b0;
      ind_timing_reg <= 1'b0;
    end
    else if (ind_expire)
    begin
      ind_lit_reg <= 1'b0;
      ind_timing_reg <= 1'b0;
    end
  end

  // Indicator drive, ready mode only
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      indicator_on <= 1'b0;
      indicator_level <= 4'h0;
    end
    else
    begin
      indicator_on <= ready_mode && ind_lit_reg;
      indicator_level <= (ready_mode && ind_lit_reg) ?
                         indicator_current_code : 4'h0;
    end
  end

endmodule

`default_nettype wire

// *** verilog/fld_step_timer.sv ***
// Step timer: counts down a 4-bit code in steps of STEP_CYCLES clocks.
// Assumes run comes from the caller's registers; load may be combinational.

`timescale 1ns/100ps
`default_nettype none

module fld_step_timer
#(
  parameter int STEP_CYCLES = fld_pkg::STEP_CYCLES
)
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic load,
  input wire logic [3:0] load_steps,
  input wire logic run,
  output logic steps_zero
);

  logic [3:0] steps_reg;
  logic [fld_pkg::PRE_W-1:0] pre_reg;
  logic step_end;

  // ==========================================================
  // Prescaler and step counter
  assign step_end = (pre_reg == fld_pkg::PRE_W'(STEP_CYCLES - 1));

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      steps_reg <= 4'h0;
      pre_reg <= '0;
    end
    else if (load)
    begin
      steps_reg <= load_steps;
      pre_reg <= '0;
    end
    else if (run && steps_reg != 4'h0)
    begin
      if (step_end)
      begin
        pre_reg <= '0;
        steps_reg <= steps_reg - 4'h1;
      end
      else
        pre_reg <= pre_reg + fld_pkg::PRE_W'(1);
    end
  end

  assign steps_zero = (steps_reg == 4'h0);

endmodule

`default_nettype wire
